// ==== inc/mir_cfg.svh ====
// Constants for the move and interrupt-return execution block
`ifndef MIR_CFG_SVH
`define MIR_CFG_SVH
`define MIR_IW 14
`define MIR_FA_W 7
`define MIR_PC_W 13
`define MIR_DEPTH 8
`define MIR_SP_W 3
`define MIR_IRQEN_BIT 7
`define MIR_RETIRQ_CYC 2'h2
`define MIR_OP_NOP 14'h0000
`define MIR_OP_RETIRQ 14'h0009
`define MIR_OP_RET 14'h0008
`define MIR_MSK_ACC2F 14'h3f80
`define MIR_PAT_ACC2F 14'h0080
`define MIR_MSK_F2DEST 14'h3f00
`define MIR_PAT_F2DEST 14'h0800
`define MIR_MSK_LITACC 14'h3c00
`define MIR_PAT_LITACC 14'h3000
`define MIR_D_BIT 7
`define MIR_PC_RST 13'h0000
`endif

// ==== inc/mir_pkg.sv ====
// Types shared by the move and interrupt-return block
`include "mir_cfg.svh"
package mir_pkg;
    typedef enum logic [2:0] {
        MIR_OP_NONE = 3'b000,
        MIR_OP_FMOVE = 3'b001,
        MIR_OP_AMOVE = 3'b010,
        MIR_OP_LIT = 3'b011,
        MIR_OP_NOPI = 3'b100,
        MIR_OP_RETI = 3'b101
    } mir_op_t;

    typedef enum logic [0:0] {
        MIR_ST_EXEC = 1'b0,
        MIR_ST_FLUSH = 1'b1
    } mir_state_t;

    typedef struct packed {
        logic we;
        logic [`MIR_FA_W-1:0] addr;
        logic [7:0] data;
    } mir_fwr_t;
endpackage : mir_pkg

// ==== verilog/mir_stack.sv ====
// Hardware return stack with a registered top-of-stack output
`timescale 1ns/1ps
`include "mir_cfg.svh"
module mir_stack
    import mir_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [`MIR_PC_W-1:0] push_data_i,
    output logic [`MIR_PC_W-1:0] top_o
);
    logic [`MIR_PC_W-1:0] mem_r [`MIR_DEPTH];
    logic [`MIR_SP_W-1:0] sp_r;
    logic [`MIR_SP_W-1:0] sp_nxt;
    logic [`MIR_PC_W-1:0] top_nxt;

    // Circular stack: overflow silently wraps and overwrites the oldest entry
    always_comb begin
        sp_nxt = sp_r;
        top_nxt = mem_r[sp_r - `MIR_SP_W'(1)];
        if (push_i) begin
            sp_nxt = sp_r + `MIR_SP_W'(1);
            top_nxt = push_data_i;
        end else if (pop_i) begin
            sp_nxt = sp_r - `MIR_SP_W'(1);
            top_nxt = mem_r[sp_r - `MIR_SP_W'(2)];
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sp_r <= '0;
            top_o <= '0;
        end else begin
            sp_r <= sp_nxt;
            top_o <= top_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (push_i) begin
            mem_r[sp_r] <= push_data_i;
        end
    end
endmodule : mir_stack

// ==== verilog/mir_core.sv ====
// Execution of file moves, literal load, no-op and return from interrupt
//
// Behaviour
// RULE_01: File move with destination zero writes the addressed register into accumulator.
// RULE_02: File move with destination one writes value back; accumulator unchanged.
// RULE_03: File move updates zero flag from moved value; one word, one cycle.
// RULE_04: Accumulator-to-file copies accumulator to register, no flags, one cycle.
// RULE_05: Literal load puts the 8-bit immediate in accumulator, flags untouched.
// RULE_06: Unused literal-load bits are don't-care; encoder fills them with zeros.
// RULE_07: Return from interrupt pops stack and loads popped top into program counter.
// RULE_08: Return from interrupt also sets global interrupt enable to one.
// RULE_09: Enable sits at bit 7 of control register; return takes two cycles.
// RULE_10: Zero flag set when moved value is all zeros, cleared otherwise.
`timescale 1ns/1ps
`include "mir_cfg.svh"
module mir_core
    import mir_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic instr_valid_i,
    input wire logic [`MIR_IW-1:0] instr_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic call_push_i,
    input wire logic [`MIR_PC_W-1:0] call_pc_i,
    input wire logic irq_ack_i,
    output logic [`MIR_FA_W-1:0] file_raddr_o,
    output mir_fwr_t file_wr_o,
    output logic [7:0] acc_o,
    output logic zero_flag_o,
    output logic [7:0] irq_control_reg_o,
    output logic [`MIR_PC_W-1:0] pc_o,
    output logic pc_load_o,
    output logic busy_o
);
    function automatic mir_op_t decode(input logic [`MIR_IW-1:0] w);
        if (w == `MIR_OP_RETIRQ) return MIR_OP_RETI;
        if (w == `MIR_OP_NOP) return MIR_OP_NOPI;
        if ((w & `MIR_MSK_ACC2F) == `MIR_PAT_ACC2F) return MIR_OP_AMOVE;
        if ((w & `MIR_MSK_F2DEST) == `MIR_PAT_F2DEST) return MIR_OP_FMOVE;
        if ((w & `MIR_MSK_LITACC) == `MIR_PAT_LITACC) return MIR_OP_LIT;
        return MIR_OP_NONE;
    endfunction : decode

    mir_state_t state_r, state_nxt;
    mir_op_t op;
    logic [7:0] acc_nxt;
    logic zero_nxt;
    logic [7:0] icr_nxt;
    logic [`MIR_PC_W-1:0] pc_nxt;
    logic pc_load_nxt;
    mir_fwr_t fwr_nxt;
    logic pop;
    logic [`MIR_PC_W-1:0] stack_top;

    // File read address is combinational from the word so the read completes in one cycle
    assign file_raddr_o = instr_i[`MIR_FA_W-1:0];
    assign op = (instr_valid_i && state_r == MIR_ST_EXEC) ? decode(instr_i) : MIR_OP_NONE;
    assign pop = (op == MIR_OP_RETI); // RULE_07

    mir_stack u_stack (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .push_i(call_push_i && !pop),
        .pop_i(pop),
        .push_data_i(call_pc_i),
        .top_o(stack_top)
    );

    always_comb begin
        state_nxt = MIR_ST_EXEC;
        acc_nxt = acc_o;
        zero_nxt = zero_flag_o;
        icr_nxt = irq_control_reg_o;
        pc_nxt = pc_o;
        pc_load_nxt = 1'b0;
        fwr_nxt = '0;
        // Entering an interrupt clears the enable; the core's interrupt logic signals it
        if (irq_ack_i) begin
            icr_nxt[`MIR_IRQEN_BIT] = 1'b0;
        end
        unique case (op)
            MIR_OP_FMOVE: begin
                if (instr_i[`MIR_D_BIT]) begin
                    fwr_nxt.we = 1'b1; // RULE_02
                    fwr_nxt.addr = instr_i[`MIR_FA_W-1:0];
                    fwr_nxt.data = file_rdata_i;
                end else begin
                    acc_nxt = file_rdata_i; // RULE_01
                end
                zero_nxt = (file_rdata_i == 8'h00); // RULE_03 RULE_10
            end
            MIR_OP_AMOVE: begin
                fwr_nxt.we = 1'b1; // RULE_04
                fwr_nxt.addr = instr_i[`MIR_FA_W-1:0];
                fwr_nxt.data = acc_o;
            end
            // Only the low byte is used; the don't-care bits are ignored
            MIR_OP_LIT: acc_nxt = instr_i[7:0]; // RULE_05 RULE_06
            MIR_OP_RETI: begin
                pc_nxt = stack_top; // RULE_07
                pc_load_nxt = 1'b1;
                icr_nxt[`MIR_IRQEN_BIT] = 1'b1; // RULE_08 RULE_09
                state_nxt = MIR_ST_FLUSH; // RULE_09
            end
            MIR_OP_NOPI, MIR_OP_NONE: ;
            default: ;
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= MIR_ST_EXEC;
            acc_o <= 8'h00;
            zero_flag_o <= 1'b0;
            irq_control_reg_o <= 8'h00;
            pc_o <= `MIR_PC_RST;
            pc_load_o <= 1'b0;
            file_wr_o <= '0;
            busy_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            acc_o <= acc_nxt;
            zero_flag_o <= zero_nxt;
            irq_control_reg_o <= icr_nxt;
            pc_o <= pc_nxt;
            pc_load_o <= pc_load_nxt;
            file_wr_o <= fwr_nxt;
            busy_o <= (state_nxt == MIR_ST_FLUSH);
        end
    end

    a_fmove_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_10
        op == MIR_OP_FMOVE |=> zero_flag_o == ($past(file_rdata_i) == 8'h00))
        else $error("zero flag wrong after file move");
    a_fmove_acc: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_01
        (op == MIR_OP_FMOVE && !instr_i[`MIR_D_BIT]) |=> acc_o == $past(file_rdata_i)
            && !file_wr_o.we)
        else $error("file move to accumulator wrong");
    a_fmove_back: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_02
        (op == MIR_OP_FMOVE && instr_i[`MIR_D_BIT]) |=> $stable(acc_o) && file_wr_o.we
            && file_wr_o.data == $past(file_rdata_i))
        else $error("file move back wrong");
    // The write-back must land on the very register that was read
    a_fmove_single: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_03
        op == MIR_OP_FMOVE |=> !busy_o
            && (!file_wr_o.we || file_wr_o.addr == $past(file_raddr_o)))
        else $error("file move not single cycle or wrong address");
    a_acc_copy: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_04
        op == MIR_OP_AMOVE |=> file_wr_o.we && file_wr_o.data == $past(acc_o)
            && $stable(zero_flag_o) && file_wr_o.addr == $past(instr_i[`MIR_FA_W-1:0]))
        else $error("accumulator to file wrong");
    a_lit_load: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_05
        op == MIR_OP_LIT |=> acc_o == $past(instr_i[7:0]) && $stable(zero_flag_o))
        else $error("literal load wrong");
    a_lit_dc: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_06
        op == MIR_OP_LIT |=> !file_wr_o.we && !pc_load_o)
        else $error("literal load side effect");
    a_ret_pc: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_07
        op == MIR_OP_RETI |=> pc_load_o && pc_o == $past(stack_top))
        else $error("return did not load top of stack");
    // Return wins over a simultaneous interrupt acknowledge
    a_ret_enable: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_08
        op == MIR_OP_RETI |=> irq_control_reg_o[`MIR_IRQEN_BIT])
        else $error("return did not set enable");
    a_ret_two: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_09
        op == MIR_OP_RETI |=> busy_o ##1 !busy_o)
        else $error("return not two cycles");
endmodule : mir_core

// ==== verif/mir_core_tb.sv ====
// Self-checking random bench for the move and interrupt-return block
`timescale 1ns/1ps
`include "mir_cfg.svh"
module mir_core_tb;
    import mir_pkg::*;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [`MIR_IW-1:0] instr_i = 14'h0000;
    logic [7:0] file_rdata_i = 8'h00;
    logic call_push_i = 1'b0;
    logic [`MIR_PC_W-1:0] call_pc_i = 13'h0000;
    logic irq_ack_i = 1'b0;
    logic [`MIR_FA_W-1:0] file_raddr_o;
    mir_fwr_t file_wr_o;
    logic [7:0] acc_o;
    logic zero_flag_o;
    logic [7:0] irq_control_reg_o;
    logic [`MIR_PC_W-1:0] pc_o;
    logic pc_load_o;
    logic busy_o;
    int n_fail = 0;
    int checks = 0;
    int seed = 32'h9c146efa;
    logic [7:0] m_acc = 8'h00;
    logic m_zero = 1'b0;
    logic m_en = 1'b0;
    logic [12:0] m_stk [8];
    logic [2:0] m_sp = 3'h0;
    int m_depth = 0;

    always #2.5 clock_i = ~clock_i;

    mir_core i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .file_rdata_i(file_rdata_i), .call_push_i(call_push_i),
        .call_pc_i(call_pc_i), .irq_ack_i(irq_ack_i), .file_raddr_o(file_raddr_o),
        .file_wr_o(file_wr_o), .acc_o(acc_o), .zero_flag_o(zero_flag_o),
        .irq_control_reg_o(irq_control_reg_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
        .busy_o(busy_o));

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // One instruction, then its effects one edge later
    task step(input logic [13:0] w, input logic [7:0] rd, input logic psh, input logic ack,
              input logic [12:0] cpc);
        logic we;
        logic [15:0] wr;
        logic ret;
        logic [12:0] epc;
        we = 1'b0;
        ret = 1'b0;
        epc = 13'h0000;
        wr = 16'h0000;
        @(negedge clock_i);
        instr_valid_i = 1'b1;
        instr_i = w;
        file_rdata_i = rd;
        call_push_i = psh;
        call_pc_i = cpc;
        irq_ack_i = ack;
        #1 chk("file_raddr", {9'h000, w[6:0]}, {9'h000, file_raddr_o});
        if (w[13:8] == 6'h08) begin
            we = w[7];
            wr = {1'b1, w[6:0], rd};
            if (!w[7]) m_acc = rd;
            m_zero = (rd == 8'h00);
        end else if (w[13:7] == 7'h01) begin
            we = 1'b1;
            wr = {1'b1, w[6:0], m_acc};
        end else if (w[13:10] == 4'hc) begin
            m_acc = w[7:0];
        end else if (w == 14'h0009) begin
            ret = 1'b1;
            epc = m_stk[m_sp];
            m_sp = m_sp - 3'h1;
            m_depth--;
            m_en = 1'b1;
        end
        if (!ret && ack) m_en = 1'b0;
        if (!ret && psh) begin
            m_sp = m_sp + 3'h1;
            m_stk[m_sp] = cpc;
            if (m_depth < 8) m_depth++;
        end
        @(posedge clock_i);
        #1;
        chk("acc", {8'h00, m_acc}, {8'h00, acc_o});
        chk("zero", {15'h0, m_zero}, {15'h0, zero_flag_o});
        chk("wr_we", {15'h0, we}, {15'h0, file_wr_o.we});
        if (we) chk("wr", wr, file_wr_o);
        chk("ctl", {8'h00, m_en, 7'h00}, {8'h00, irq_control_reg_o});
        chk("pc_load", {15'h0, ret}, {15'h0, pc_load_o});
        chk("busy", {15'h0, ret}, {15'h0, busy_o});
        if (ret) begin
            chk("pc", {3'h0, epc}, {3'h0, pc_o});
            // Word offered while busy must be dropped silently
            @(negedge clock_i);
            instr_i = 14'h30a5;
            call_push_i = 1'b0;
            irq_ack_i = 1'b0;
            @(posedge clock_i);
            #1 chk("acc_busy", {8'h00, m_acc}, {8'h00, acc_o});
            chk("busy_end", 16'h0000, {15'h0, busy_o});
        end
    endtask : step

    initial begin
        logic [31:0] r;
        logic [13:0] w;
        repeat (16) @(negedge clock_i);
        sys_rst_i = 1'b0;
        chk("acc_rst", 16'h0000, {8'h00, acc_o});
        step(14'h305a, 8'h11, 1'b1, 1'b0, 13'h1abc);
        step(14'h00ff, 8'h22, 1'b1, 1'b0, 13'h0123);
        step(14'h0800, 8'h00, 1'b0, 1'b1, 13'h0000);
        step(14'h08ff, 8'h4f, 1'b0, 1'b0, 13'h0000);
        step(14'h0009, 8'h00, 1'b0, 1'b0, 13'h0000);
        step(14'h0009, 8'h00, 1'b0, 1'b0, 13'h0000);
        // A word without its valid strobe must leave the accumulator alone
        @(negedge clock_i);
        instr_valid_i = 1'b0;
        instr_i = 14'h30c3;
        @(posedge clock_i);
        #1 chk("acc_idle", {8'h00, m_acc}, {8'h00, acc_o});
        for (int i = 0; i < 600; i++) begin
            r = $random(seed);
            case (r[2:0])
                3'h2: w = {7'h01, r[14:8]};
                3'h3: w = {4'hc, r[9:8], r[23:16]};
                3'h4: w = 14'h0000;
                3'h5: w = (m_depth > 0) ? 14'h0009 : 14'h3f00;
                default: w = {6'h08, r[7], r[14:8]};
            endcase
            step(w, r[17:16] == 2'h0 ? 8'h00 : r[31:24], r[20] && w != 14'h0009,
                 r[21] && r[22], r[31:19]);
        end
        finish_test();
    end
endmodule : mir_core_tb
